// ---- rtl/strap_cfg_pkg.sv ----
/*
 * strap_cfg_pkg: constants and carrier types for the resistor strap loader.
 * Assumes an analog front end that bins each strap pin's divider ratio into a
 * 5-bit code before this logic sees it.
 */
package strap_cfg_pkg;

  localparam int unsigned NUM_CHAN      = 2;
  localparam int unsigned CODE_W        = 5;
  localparam int unsigned MV_W          = 16;
  localparam int unsigned KHZ_W         = 11;

  // timing: strap dividers and the front end settle before the capture
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_SETTLE_US   = 100;
  localparam int unsigned SETTLE_CYC    = (T_SETTLE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 20;

  // strap bin codes shared by every strap pin
  localparam logic [4:0] CODE_FROM_NVM  = 5'h00; // top 0 or open, bottom open
  localparam logic [4:0] CODE_FIRST_SET = 5'h01; // first fixed setting
  localparam logic [4:0] CODE_LAST_VOUT = 5'h0F; // last of fifteen setpoints
  localparam logic [4:0] CODE_LAST_FREQ = 5'h0B; // last of eleven frequencies
  localparam logic [4:0] CODE_TOP_OPEN  = 5'h10; // top open, bottom shorted

  // percentages of the setpoint for the dependent limits
  localparam logic [7:0] PCT_OV         = 8'h6E; // 110 %
  localparam logic [7:0] PCT_UV         = 8'h5A; // 90 %
  localparam logic [7:0] PCT_PG_HI      = 8'h6B; // 107 %
  localparam logic [7:0] PCT_PG_LO      = 8'h5D; // 93 %
  localparam logic [7:0] PCT_FULL       = 8'h64; // 100 %

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } load_state_e;

  // one channel's decoded start-up configuration
  typedef struct packed {
    logic [MV_W-1:0] vout_mv;
    logic [MV_W-1:0] ov_mv;
    logic [MV_W-1:0] uv_mv;
    logic [MV_W-1:0] pg_hi_mv;
    logic [MV_W-1:0] pg_lo_mv;
    logic            from_nvm;
    logic            hold_off;
  } chan_cfg_s;

  // device-wide straps
  typedef struct packed {
    logic [KHZ_W-1:0]  freq_khz;
    logic              freq_from_nvm;
    logic              ext_sync_only;
    logic [CODE_W-1:0] phase_code;
    logic [CODE_W-1:0] addr_hi_code;
    logic [CODE_W-1:0] addr_lo_code;
  } dev_cfg_s;

endpackage : strap_cfg_pkg

// ---- rtl/strap_cfg_loader.sv ----
/*
 * strap_cfg_loader: samples the resistor strap bins once after power-up or a
 * reset command, decodes them into start-up settings and gates channel start.
 * Assumes strap bins, run pins and the sync detector are asynchronous; the
 * operation command, reload pulse and nonvolatile values are on i_clk.
 * The settle wait is a fixed count, so slow dividers need a larger
 * SETTLE_CYCLES; nothing checks that the bins have really settled.
 */
// How it works
// - start-up settings come from the strap dividers, no programming needed
// - straps set output voltage, frequency, phase placement and bus address
// - straps are sampled only after power-up or a reset, later changes ignored
// - output strap picks one of fifteen setpoints, 5.0 V down to 0.6 V
// - a decoded strap acts exactly like writing the setpoint command
// - top-open strap loads setpoint from memory, channel held off until commanded
// - a strapped setpoint also sets dependent limits as percentages of it
// - external-clock-only frequency strap blocks start without a sync clock
`timescale 1ns/10ps
module strap_cfg_loader
  import strap_cfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_resetn,
  input  wire logic                             i_reload,
  input  wire logic [NUM_CHAN-1:0][CODE_W-1:0]  i_vout_strap,
  input  wire logic [CODE_W-1:0]                i_freq_strap,
  input  wire logic [CODE_W-1:0]                i_phase_strap,
  input  wire logic [CODE_W-1:0]                i_addr_hi_strap,
  input  wire logic [CODE_W-1:0]                i_addr_lo_strap,
  input  wire logic [NUM_CHAN-1:0]              i_channel_run_pin,
  input  wire logic                             i_sync_clk_present,
  input  wire logic [NUM_CHAN-1:0]              i_operation_on,
  input  wire logic [NUM_CHAN-1:0][MV_W-1:0]    i_nvm_vout_mv,
  input  wire logic [KHZ_W-1:0]                 i_nvm_freq_khz,
  output logic      [NUM_CHAN-1:0]              o_cfg_valid,
  output chan_cfg_s [NUM_CHAN-1:0]              o_chan_cfg,
  output dev_cfg_s                              o_dev_cfg,
  output logic      [NUM_CHAN-1:0]              o_output_voltage_setpoint_cmd_we,
  output logic      [NUM_CHAN-1:0]              o_chan_start
);

  // strap word, high to low: output straps, frequency, phase, address high, low
  localparam int unsigned STRAP_W = (NUM_CHAN + 4) * CODE_W;

  // every register of the block, so one reset branch clears it all
  typedef struct packed {
    load_state_e                    st;
    logic [CNT_W-1:0]               cnt;
    logic [STRAP_W-1:0]             strap_m;   // first sync stage
    logic [STRAP_W-1:0]             strap_s;
    logic [NUM_CHAN:0]              lvl_m;     // run pins and sync detector
    logic [NUM_CHAN:0]              lvl_s;
    logic                           valid;
    logic [NUM_CHAN-1:0]            we;
    chan_cfg_s [NUM_CHAN-1:0]       chan;
    dev_cfg_s                       dev;
    logic [NUM_CHAN-1:0]            start;
  } state_s;

  // registered state and its next value
  state_s r_q;
  state_s r_d;

  // fifteen fixed setpoints; out-of-range codes never reach here
  function automatic logic [MV_W-1:0] vout_of(input logic [CODE_W-1:0] c);
    unique case (c)
      5'h01:   vout_of = 16'h1388; // 5000 mV
      5'h02:   vout_of = 16'h0CE4; // 3300 mV
      5'h03:   vout_of = 16'h09C4; // 2500 mV
      5'h04:   vout_of = 16'h0708; // 1800 mV
      5'h05:   vout_of = 16'h05DC; // 1500 mV
      5'h06:   vout_of = 16'h0546; // 1350 mV
      5'h07:   vout_of = 16'h04E2; // 1250 mV
      5'h08:   vout_of = 16'h04B0; // 1200 mV
      5'h09:   vout_of = 16'h047E; // 1150 mV
      5'h0A:   vout_of = 16'h044C; // 1100 mV
      5'h0B:   vout_of = 16'h041A; // 1050 mV
      5'h0C:   vout_of = 16'h0384; // 900 mV
      5'h0D:   vout_of = 16'h02EE; // 750 mV
      5'h0E:   vout_of = 16'h028A; // 650 mV
      default: vout_of = 16'h0258; // 600 mV, code 0x0F
    endcase
  endfunction : vout_of

  // eleven fixed switching frequencies in kHz
  function automatic logic [KHZ_W-1:0] freq_of(input logic [CODE_W-1:0] c);
    unique case (c)
      5'h01:   freq_of = 11'h4E2; // 1250
      5'h02:   freq_of = 11'h3E8; // 1000
      5'h03:   freq_of = 11'h384; // 900
      5'h04:   freq_of = 11'h2EE; // 750
      5'h05:   freq_of = 11'h258; // 600
      5'h06:   freq_of = 11'h1F4; // 500
      5'h07:   freq_of = 11'h1C2; // 450
      5'h08:   freq_of = 11'h190; // 400
      5'h09:   freq_of = 11'h15E; // 350
      5'h0A:   freq_of = 11'h12C; // 300
      default: freq_of = 11'h0FA; // 250, code 0x0B
    endcase
  endfunction : freq_of

  // scaled limit; the product fits 24 bits, a quotient past 16 bits is clamped
  // so a near full-scale stored setpoint cannot wrap round to a tiny limit
  function automatic logic [MV_W-1:0] pct_of(input logic [MV_W-1:0] mv,
                                             input logic [7:0]       pct);
    logic [23:0] prod;
    logic [23:0] quo;
    prod   = 24'(mv) * 24'(pct);
    quo    = prod / 24'(PCT_FULL);
    pct_of = (quo > 24'h00FFFF) ? '1 : MV_W'(quo);
  endfunction : pct_of

  // next-state logic for the whole block
  always_comb begin
    logic [CODE_W-1:0] c;
    logic              ext_ok;
    logic [MV_W-1:0]   mv;
    c      = '0;
    ext_ok = 1'b0;
    mv     = '0;
    r_d    = r_q;
    r_d.we = '0;
    // two-stage synchronisers; only the second stage feeds logic
    r_d.strap_m = {i_vout_strap, i_freq_strap, i_phase_strap,
                   i_addr_hi_strap, i_addr_lo_strap};
    r_d.strap_s = r_q.strap_m;
    r_d.lvl_m   = {i_sync_clk_present, i_channel_run_pin};
    r_d.lvl_s   = r_q.lvl_m;

    unique case (r_q.st)
      ST_SETTLE: begin
        // let dividers and the bin converter settle before trusting them
        if (r_q.cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
          r_d.st  = ST_SAMPLE;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + CNT_W'(1);
        end
      end
      ST_SAMPLE: begin
        // one capture of every strap, then frozen until the next reset
        r_d.st    = ST_RUN;
        r_d.valid = 1'b1;
        for (int i = 0; i < NUM_CHAN; i++) begin
          c = r_q.strap_s[(i + 4) * CODE_W +: CODE_W];
          if (c >= CODE_FIRST_SET && c <= CODE_LAST_VOUT) begin
            mv                   = vout_of(c);
            r_d.chan[i].from_nvm = 1'b0;
            r_d.chan[i].hold_off = 1'b0;
          end else begin
            // open/open, top-open and unknown bins keep the stored value
            mv                   = i_nvm_vout_mv[i];
            r_d.chan[i].from_nvm = 1'b1;
            r_d.chan[i].hold_off = (c == CODE_TOP_OPEN);
          end
          // same path as a setpoint command write, limits follow it
          r_d.chan[i].vout_mv  = mv;
          r_d.we[i]            = 1'b1;
          r_d.chan[i].ov_mv    = pct_of(mv, PCT_OV);
          r_d.chan[i].uv_mv    = pct_of(mv, PCT_UV);
          r_d.chan[i].pg_hi_mv = pct_of(mv, PCT_PG_HI);
          r_d.chan[i].pg_lo_mv = pct_of(mv, PCT_PG_LO);
        end
        c = r_q.strap_s[3 * CODE_W +: CODE_W];
        r_d.dev.ext_sync_only = (c == CODE_TOP_OPEN);
        if (c >= CODE_FIRST_SET && c <= CODE_LAST_FREQ) begin
          r_d.dev.freq_khz      = freq_of(c);
          r_d.dev.freq_from_nvm = 1'b0;
        end else begin
          r_d.dev.freq_khz      = i_nvm_freq_khz;
          r_d.dev.freq_from_nvm = (c != CODE_TOP_OPEN);
        end
        // phase and address bins are decoded by their consumers
        r_d.dev.phase_code   = r_q.strap_s[2 * CODE_W +: CODE_W];
        r_d.dev.addr_hi_code = r_q.strap_s[CODE_W +: CODE_W];
        r_d.dev.addr_lo_code = r_q.strap_s[0 +: CODE_W];
      end
      ST_RUN: begin
        // a reset command drops valid and start, keeps the decoded settings and re-reads the straps
        // strap pins are not decoded here, so divider changes in run are dropped
        if (i_reload) begin
          r_d.st    = ST_SETTLE;
          r_d.cnt   = '0;
          r_d.valid = 1'b0;
        end
      end
      default: begin
        // the spare state code falls back to settling
        r_d.st = ST_SETTLE;
      end
    endcase

    // start needs config, operation and run pin, plus a clock if sync-only
    // a held-off channel is gated like the others: it waits for operation and run
    ext_ok = ~r_q.dev.ext_sync_only | r_q.lvl_s[NUM_CHAN];
    for (int i = 0; i < NUM_CHAN; i++) begin
      r_d.start[i] = r_q.valid & ext_ok & i_operation_on[i]
                     & r_q.lvl_s[i];
    end
    if (r_q.st != ST_RUN || i_reload) begin
      r_d.start = '0;
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs come straight from the state register
  assign o_cfg_valid                      = {NUM_CHAN{r_q.valid}};
  assign o_chan_cfg                       = r_q.chan;
  assign o_dev_cfg                        = r_q.dev;
  assign o_output_voltage_setpoint_cmd_we = r_q.we;
  assign o_chan_start                     = r_q.start;

endmodule : strap_cfg_loader

// ---- tb/strap_cfg_loader_assertions.sv ----
/* strap_cfg_loader_assertions: port timing and limit relations of the loader.
   assumes the bench settle count of 4, so a recapture spans 5 idle cycles. */
`timescale 1ns/10ps
module strap_cfg_loader_assertions
  import strap_cfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  input wire logic                 i_reload,
  input wire logic [NUM_CHAN-1:0]  i_channel_run_pin,
  input wire logic                 i_sync_clk_present,
  input wire logic [NUM_CHAN-1:0]  i_operation_on,
  input wire logic [NUM_CHAN-1:0]  o_cfg_valid,
  input wire chan_cfg_s [NUM_CHAN-1:0] o_chan_cfg,
  input wire dev_cfg_s             o_dev_cfg,
  input wire logic [NUM_CHAN-1:0]  o_output_voltage_setpoint_cmd_we,
  input wire logic [NUM_CHAN-1:0]  o_chan_start
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // a reload taken while decoded, and the recapture that must follow it
  sequence reload_hit;
    o_cfg_valid[0] && i_reload;
  endsequence
  sequence recapture;
    !o_cfg_valid[0] [*5] ##1 o_cfg_valid[0];
  endsequence

  chk_recapture_span: assert property (reload_hit |=> recapture)
    else $error("recapture span wrong");
  chk_reload_clears: assert property (reload_hit |=> o_chan_start == 2'h0)
    else $error("start not cleared by reload");
  chk_cfg_frozen: assert property (
    $past(o_cfg_valid[0]) && o_cfg_valid[0] |-> $stable(o_chan_cfg) && $stable(o_dev_cfg))
    else $error("decoded settings moved while valid");
  chk_we_on_capture: assert property (
    o_output_voltage_setpoint_cmd_we == ($rose(o_cfg_valid[0]) ? 2'h3 : 2'h0))
    else $error("setpoint write not tied to capture");
  chk_start_op: assert property (
    o_chan_start[0] |-> o_cfg_valid[0] && $past(i_operation_on[0]))
    else $error("start without operation on");
  chk_start_run: assert property (
    o_chan_start[1] |-> $past(i_channel_run_pin[1], 3))
    else $error("start without run pin");
  chk_start_sync: assert property (
    o_chan_start[0] && o_dev_cfg.ext_sync_only |-> $past(i_sync_clk_present, 3))
    else $error("start without sync clock");
  chk_ov_limit: assert property (
    o_cfg_valid[1] |-> 32'(o_chan_cfg[1].ov_mv) == 32'(o_chan_cfg[1].vout_mv) * 110 / 100)
    else $error("over-voltage limit wrong");
endmodule : strap_cfg_loader_assertions

bind strap_cfg_loader strap_cfg_loader_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_reload(i_reload),
  .i_channel_run_pin(i_channel_run_pin), .i_sync_clk_present(i_sync_clk_present),
  .i_operation_on(i_operation_on), .o_cfg_valid(o_cfg_valid), .o_chan_cfg(o_chan_cfg),
  .o_dev_cfg(o_dev_cfg), .o_output_voltage_setpoint_cmd_we(o_output_voltage_setpoint_cmd_we),
  .o_chan_start(o_chan_start));

// ---- tb/strap_divider_model.sv ----
/* strap_divider_model: the resistor dividers on the output and frequency strap pins, seen as bins.
   assumes the bench picks one divider code per pin. */
`timescale 1ns/10ps
module strap_divider_model
  import strap_cfg_pkg::*;
(
  input  wire logic                            i_clk,
  input  wire logic [NUM_CHAN-1:0][CODE_W-1:0] i_vout_code,
  input  wire logic [CODE_W-1:0]               i_freq_code,
  output logic      [NUM_CHAN-1:0][CODE_W-1:0] o_vout_strap,
  output logic      [CODE_W-1:0]               o_freq_strap
);
  // a divider is a static level; one clock of lag stands in for rc settling
  always_ff @(posedge i_clk) begin
    o_vout_strap <= i_vout_code;
    o_freq_strap <= i_freq_code;
  end
endmodule : strap_divider_model

// ---- tb/tb_top.sv ----
/* tb_top: strap loader bench with a reference decode of every capture.
   assumes the divider model and the bound checker. */
`timescale 1ns/10ps
module tb_top;
  import strap_cfg_pkg::*;
  logic clk = 0, resetn = 0, rld = 0, sync = 0;
  logic [1:0] run = '0, op = '0, valid, we, start;
  logic [1:0][4:0] vc = '0, vs, cv;
  logic [4:0] fc = '0, fs, cf, ph = '0;
  logic [1:0][15:0] nv = '0;
  logic [10:0] nf = '0;
  chan_cfg_s [1:0] cc;
  dev_cfg_s dc;
  int bad_count = 0, comparisons = 0;
  int vt[15] = '{5000, 3300, 2500, 1800, 1500, 1350, 1250, 1200, 1150, 1100, 1050, 900, 750,
                 650, 600};
  int ft[11] = '{1250, 1000, 900, 750, 600, 500, 450, 400, 350, 300, 250};

  strap_divider_model div (.i_clk(clk), .i_vout_code(vc), .i_freq_code(fc),
    .o_vout_strap(vs), .o_freq_strap(fs));
  strap_cfg_loader #(.SETTLE_CYCLES(4)) uut (.i_clk(clk), .i_resetn(resetn), .i_reload(rld),
    .i_vout_strap(vs), .i_freq_strap(fs), .i_phase_strap(ph), .i_addr_hi_strap(ph),
    .i_addr_lo_strap(~ph), .i_channel_run_pin(run), .i_sync_clk_present(sync),
    .i_operation_on(op), .i_nvm_vout_mv(nv), .i_nvm_freq_khz(nf), .o_cfg_valid(valid),
    .o_chan_cfg(cc), .o_dev_cfg(dc), .o_output_voltage_setpoint_cmd_we(we), .o_chan_start(start));

  always #5 clk = ~clk;

  task chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk

  // reference decode of the captured codes, field by field
  task check_cfg;
    int v, f;
    for (int c = 0; c < 2; c++) begin
      v = (cv[c] inside {[1:15]}) ? vt[cv[c] - 1] : nv[c];
      chk("vout", v, cc[c].vout_mv);
      chk("ov", v * 110 / 100, cc[c].ov_mv);
      chk("uv", v * 90 / 100, cc[c].uv_mv);
      chk("pghi", v * 107 / 100, cc[c].pg_hi_mv);
      chk("pglo", v * 93 / 100, cc[c].pg_lo_mv);
      chk("nvm", !(cv[c] inside {[1:15]}), cc[c].from_nvm);
      chk("hold", cv[c] == 5'h10, cc[c].hold_off);
    end
    f = (cf inside {[1:11]}) ? ft[cf - 1] : nf;
    chk("freq", f, dc.freq_khz);
    chk("ext", cf == 5'h10, dc.ext_sync_only);
    chk("fnvm", !(cf inside {[1:11], 16}), dc.freq_from_nvm);
    chk("addr", {ph, ph, ~ph}, {dc.phase_code, dc.addr_hi_code, dc.addr_lo_code});
  endtask : check_cfg

  // wait for the setpoint write pulse; the strap codes were set before it
  task capture;
    cv = vc;
    cf = fc;
    for (int i = 0; i < 20 && we !== 2'h3; i++) begin
      @(posedge clk);
      #1;
    end
    chk("we", 2'h3, we);
    check_cfg();
  endtask : capture

  task give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // main sequence: every code once, then freeze, start gating and a second reset
  initial begin
    void'($urandom(25));
    repeat (4) @(posedge clk);
    resetn <= 1;
    capture();
    for (int r = 0; r < 16; r++) begin
      @(posedge clk);
      vc <= {5'(r + 4), 5'(r)};
      fc <= (r == 15) ? 5'h10 : 5'(r);
      ph <= 5'($urandom);
      nv <= {16'($urandom_range(6000)), 16'($urandom_range(6000))};
      nf <= 11'($urandom_range(1250));
      @(posedge clk);
      rld <= 1;
      @(posedge clk);
      rld <= 0;
      capture();
    end
    @(posedge clk);
    vc <= {5'($urandom_range(15, 1)), 5'h02};
    fc <= 5'h03;
    op <= 2'h3;
    run <= 2'h3;
    repeat (8) @(posedge clk);
    #1;
    check_cfg();
    chk("start", 2'h0, start);
    @(posedge clk);
    sync <= 1;
    for (int k = 0; k < 6; k++) begin
      repeat (5) @(posedge clk);
      #1;
      chk("start", op & run, start);
      @(posedge clk);
      op <= 2'($urandom);
      run <= 2'($urandom);
    end
    resetn <= 0;
    @(posedge clk);
    #1;
    chk("reset", 4'h0, {valid, start});
    @(posedge clk);
    resetn <= 1;
    capture();
    give_verdict();
  end
endmodule : tb_top
